// ==== btu_cpu_model.sv ====
// Processor bus and debug controller side model feeding the trace unit
module btu_cpu_model (
   input  logic        core_clk,
   output logic [15:0] cpu_addr,
   output logic [7:0]  cpu_rdata,
   output logic [7:0]  cpu_wdata,
   output logic        cpu_rw,
   output logic        cpu_valid,
   output logic        cpu_exec,
   output logic [15:0] cpu_exec_addr,
   output logic        cpu_cof,
   output logic [15:0] cpu_cof_addr,
   output logic        sw_dbg_access
);
   timeunit 1ns;
   timeprecision 1ps;
   // Bus idle at start
   initial begin
      {cpu_addr, cpu_exec_addr, cpu_cof_addr, cpu_rdata, cpu_wdata} = 64'h0;
      {cpu_rw, sw_dbg_access, cpu_cof, cpu_exec, cpu_valid} = 5'h00;
   end

   // One event, k = {rw, dbg, cof, exec, valid}; released lines show inverted leftovers
   task automatic cyc(input logic [15:0] a, input logic [7:0] rd, input logic [7:0] wd,
                      input logic [4:0] k);
      @(posedge core_clk);
      {cpu_addr, cpu_exec_addr, cpu_cof_addr} <= {a, a, a};
      {cpu_rdata, cpu_wdata} <= {rd, wd};
      {cpu_rw, sw_dbg_access, cpu_cof, cpu_exec, cpu_valid} <= k;
      @(posedge core_clk);
      {cpu_addr, cpu_exec_addr, cpu_cof_addr} <= ~{a, a, a};
      {cpu_rdata, cpu_wdata} <= ~{rd, wd};
      {sw_dbg_access, cpu_cof, cpu_exec, cpu_valid} <= 4'h0;
   endtask
endmodule

// ==== btu_defines.vh ====
// Constants for the bus trace and trigger unit
//
// Notes on behaviour
// R1 - Eight-entry capture FIFO of bus words
// R2 - Two 16-bit comparators, optional qualifiers
// R3 - Per-comparator bit ignores read/write direction
// R4 - Opcode tracking triggers only on execution; the data compare and data store modes ignore the tag bit and match bus cycles
// R5 - Magnitude compare gives inside/outside range
// R6 - No matching during debug controller accesses
// R7 - Comparator A always sees full address
// R8 - Comparator B sees address or data
// R9 - Full data modes: write bus if enabled-write
// R10 - Match raises breakpoint or stores data
// R11 - Trace match begins or ends flow storage
// R12 - Stop storing when full or ended
// R13 - Count tracks valid words as stored
// R14 - Host configures, arms, then reads FIFO
// R15 - Early manual halt shifts entries one place
// R16 - Registers reachable from single-wire link too
// R17 - Registers decoded in high register region
// R18 - FIFO read returns oldest, pops, decrements
// R19 - Arming clears count and enables trigger
`ifndef BTU_DEFINES_VH
`define BTU_DEFINES_VH

// ****************************************
// Register map
// ****************************************
`define BTU_BASE_HI   12'h180
`define BTU_OFF_CAH   4'h0
`define BTU_OFF_CAL   4'h1
`define BTU_OFF_CBH   4'h2
`define BTU_OFF_CBL   4'h3
`define BTU_OFF_FIFOH 4'h4
`define BTU_OFF_FIFOL 4'h5
`define BTU_OFF_CTRL  4'h6
`define BTU_OFF_TRIG  4'h7
`define BTU_OFF_STAT  4'h8
`define BTU_OFF_ISTAT 4'h9
`define BTU_OFF_IMASK 4'ha

// ****************************************
// Control register fields
// ****************************************
`define BTU_CTRL_ARM   7
`define BTU_CTRL_BRK   6
`define BTU_CTRL_TAG   5
`define BTU_CTRL_BEGIN 4
`define BTU_CTRL_COMP_A_RW_QUALIFY_ENABLE 3
`define BTU_CTRL_RWA   2
`define BTU_CTRL_RWBEN 1
`define BTU_CTRL_RWB   0

// ****************************************
// Trigger modes
// ****************************************
`define BTU_MODE_A      4'h0
`define BTU_MODE_A_OR_B 4'h1
`define BTU_MODE_A_DAT  4'h2
`define BTU_MODE_A_NDAT 4'h3
`define BTU_MODE_INSIDE 4'h4
`define BTU_MODE_OUTSID 4'h5
`define BTU_MODE_B_DAT  4'h6

// ****************************************
// Reset values
// ****************************************
`define BTU_RST_BYTE  8'h00
`define BTU_RST_WORD  16'h0000
`define BTU_RST_MODE  4'h0
`define BTU_RST_IRQ   3'h0

`endif

// ==== btu_properties.sv ====
// Port-level checks for the bus trace and trigger unit
module btu_properties (
   input logic        core_clk,
   input logic        rst,
   input logic        cpu_valid,
   input logic        cpu_exec,
   input logic        cpu_cof,
   input logic        sw_dbg_access,
   input logic [15:0] reg_addr,
   input logic        reg_wr,
   input logic        reg_rd,
   input logic [7:0]  reg_rdata,
   input logic        sw_wr,
   input logic        sw_rd,
   input logic [7:0]  sw_rdata,
   input logic        cpu_break_req,
   input logic        irq
);
   timeunit 1ns;
   timeprecision 1ps;
   logic quiet;

   default clocking dck @(posedge core_clk);
   endclocking
   default disable iff (rst);

   // No watched input or register write this cycle
   assign quiet = !cpu_valid && !cpu_exec && !cpu_cof && !reg_wr && !sw_wr;

   // ****
   // Checks
   // ****
   rdata_idle_a: assert property (reg_rdata != 8'h00 |-> $past(reg_rd))
      else $error("reg_rdata set without a read");
   sw_idle_a: assert property (sw_rdata != 8'h00 |-> $past(sw_rd))
      else $error("sw_rdata set without a read");
   sw_first_a: assert property (reg_rd && (sw_rd || sw_wr) |=> reg_rdata == 8'h00)
      else $error("reg port not yielded to link port");
   unmapped_rd_a: assert property (reg_rd && !sw_rd && !sw_wr &&
      (reg_addr[15:4] != 12'h180 || reg_addr[3:0] > 4'ha) |=> reg_rdata == 8'h00)
      else $error("unmapped read returned data");
   brk_pulse_a: assert property (cpu_break_req |=> !cpu_break_req)
      else $error("break request longer than one cycle");
   brk_cause_a: assert property (cpu_break_req |-> $past(cpu_valid || cpu_exec))
      else $error("break request without a bus event");
   brk_block_a: assert property ($past(sw_dbg_access) |-> !cpu_break_req)
      else $error("break during debug controller access");
   irq_quiet_a: assert property (quiet [*4] |-> $stable(irq))
      else $error("irq moved with no cause");

   cover property (cpu_break_req);
   cover property (irq);
   cover property (reg_rd ##1 reg_rdata != 8'h00);
endmodule

bind btu_top btu_properties btu_properties_inst (.core_clk(core_clk), .rst(rst),
   .cpu_valid(cpu_valid), .cpu_exec(cpu_exec), .cpu_cof(cpu_cof),
   .sw_dbg_access(sw_dbg_access), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
   .cpu_break_req(cpu_break_req), .irq(irq));

// ==== btu_top.v ====
// Bus trace and trigger unit: comparators, trigger logic, capture FIFO, registers
`include "btu_defines.vh"

module btu_top #(
   parameter DEPTH = 8,
   parameter AW    = 3,
   parameter CW    = 4
) (
   input  wire        core_clk,
   input  wire        rst,
   input  wire [15:0] cpu_addr,
   input  wire [7:0]  cpu_rdata,
   input  wire [7:0]  cpu_wdata,
   input  wire        cpu_rw,
   input  wire        cpu_valid,
   input  wire        cpu_exec,
   input  wire [15:0] cpu_exec_addr,
   input  wire        cpu_cof,
   input  wire [15:0] cpu_cof_addr,
   input  wire        sw_dbg_access,
   input  wire [15:0] reg_addr,
   input  wire [7:0]  reg_wdata,
   input  wire        reg_wr,
   input  wire        reg_rd,
   output reg  [7:0]  reg_rdata,
   input  wire [15:0] sw_addr,
   input  wire [7:0]  sw_wdata,
   input  wire        sw_wr,
   input  wire        sw_rd,
   output reg  [7:0]  sw_rdata,
   output reg         cpu_break_req,
   output wire        irq
);

   // Count limits sized to the counter; pointers wrap at DEPTH,
   // so DEPTH must be a power of two equal to 2**AW
   localparam [CW-1:0] FULL_CNT = DEPTH[CW-1:0];
   localparam [CW-1:0] CNT_ONE  = {{(CW-1){1'b0}}, 1'b1};

   // ****************************************
   // Register access decode
   // ****************************************

   // Configuration, trigger state and capture FIFO storage
   reg [15:0] comp_a_ff;
   reg [15:0] comp_b_ff;
   reg [7:0]  ctrl_ff;
   reg [3:0]  mode_ff;
   reg [2:0]  ist_ff;
   reg [2:0]  imask_ff;
   reg        trig_seen_ff;
   reg        storing_ff;
   reg        pend_v_ff;
   reg [15:0] pend_ff;
   reg [AW-1:0] wp_ff;
   reg [AW-1:0] rp_ff;
   reg [CW-1:0] cnt_ff;
   reg [15:0] mem [0:DEPTH-1];

   // Link port wins when both ports access in one cycle
   wire        sw_sel   = sw_wr | sw_rd;
   wire [15:0] acc_addr = sw_sel ? sw_addr : reg_addr;
   wire [7:0]  acc_wd   = sw_sel ? sw_wdata : reg_wdata;
   wire        acc_wr   = sw_sel ? sw_wr : reg_wr;
   wire        acc_rd   = sw_sel ? sw_rd : reg_rd;
   wire        hit      = (acc_addr[15:4] == `BTU_BASE_HI); // [R17]
   wire [3:0]  off      = acc_addr[3:0];
   wire        wr_en    = acc_wr & hit; // [R16]
   wire        rd_en    = acc_rd & hit; // [R16]

   // Control fields
   wire arm     = ctrl_ff[`BTU_CTRL_ARM];
   wire brk_en  = ctrl_ff[`BTU_CTRL_BRK];
   wire tag_en  = ctrl_ff[`BTU_CTRL_TAG];
   wire t_begin = ctrl_ff[`BTU_CTRL_BEGIN];
   wire comp_a_rw_qualify_enable  = ctrl_ff[`BTU_CTRL_COMP_A_RW_QUALIFY_ENABLE];
   wire comp_a_rw_direction_select = ctrl_ff[`BTU_CTRL_RWA];
   wire rwb_en  = ctrl_ff[`BTU_CTRL_RWBEN];
   wire rwb     = ctrl_ff[`BTU_CTRL_RWB];

   // ****************************************
   // Comparators
   // ****************************************

   // Matching is blocked while the debug controller owns the bus
   wire cyc_ok = cpu_valid & ~sw_dbg_access; // [R6]
   wire ex_ok  = cpu_exec & ~sw_dbg_access;  // [R6]

   // Data comparisons in full address plus data modes and in data store mode
   wire data_mode = (mode_ff == `BTU_MODE_A_DAT) | (mode_ff == `BTU_MODE_A_NDAT) |
                    (mode_ff == `BTU_MODE_B_DAT);
   wire use_wbus  = comp_a_rw_qualify_enable & ~comp_a_rw_direction_select;
   wire [7:0] bus_data = use_wbus ? cpu_wdata : cpu_rdata; // [R9]

   // Direction qualifiers, each with its own ignore bit
   wire a_rw_ok = ~comp_a_rw_qualify_enable |
                  (cpu_rw == comp_a_rw_direction_select); // [R3]
   wire b_rw_ok = ~rwb_en | (cpu_rw == rwb); // [R3]

   // Bus cycle matches; A always on the address
   wire a_hit = cyc_ok & a_rw_ok & (cpu_addr == comp_a_ff); // [R2] [R7]
   wire b_hit = cyc_ok & b_rw_ok &
                (data_mode ? (bus_data == comp_b_ff[7:0])
                           : (cpu_addr == comp_b_ff)); // [R8]
   wire in_rng = (cpu_addr >= comp_a_ff) & (cpu_addr <= comp_b_ff); // [R5]

   // Execution matches for opcode tracking
   wire ea_hit = ex_ok & (cpu_exec_addr == comp_a_ff); // [R4]
   wire eb_hit = ex_ok & (cpu_exec_addr == comp_b_ff); // [R4]
   wire ex_in  = (cpu_exec_addr >= comp_a_ff) & (cpu_exec_addr <= comp_b_ff);

   // ****************************************
   // Trigger selection
   // ****************************************

   reg qual;
   // Qualified match for the selected trigger mode
   always @* begin
      case (mode_ff)
         `BTU_MODE_A: begin
            qual = tag_en ? ea_hit : a_hit; // [R4]
         end
         `BTU_MODE_A_OR_B: begin
            qual = tag_en ? (ea_hit | eb_hit) : (a_hit | b_hit);
         end
         `BTU_MODE_A_DAT: begin
            qual = a_hit & b_hit;
         end
         `BTU_MODE_A_NDAT: begin
            qual = a_hit & ~b_hit;
         end
         `BTU_MODE_INSIDE: begin
            qual = tag_en ? (ex_ok & ex_in) : (cyc_ok & a_rw_ok & in_rng); // [R5]
         end
         `BTU_MODE_OUTSID: begin
            qual = tag_en ? (ex_ok & ~ex_in) : (cyc_ok & a_rw_ok & ~in_rng); // [R5]
         end
         `BTU_MODE_B_DAT: begin
            qual = b_hit;
         end
         default: begin
            qual = 1'b0;
         end
      endcase
   end

   // Trigger fires once per arming; data store mode fires on every match
   wire dstore  = (mode_ff == `BTU_MODE_B_DAT);
   wire trig    = arm & qual & (dstore | ~trig_seen_ff); // [R19]
   wire full    = (cnt_ff == FULL_CNT);

   // ****************************************
   // Capture path
   // ****************************************

   // A word is taken from the flow bus when storage is active, or from the data bus on a data store trigger
   wire cof_cap  = arm & ~brk_en & ~dstore & storing_ff & cpu_cof &
                   ~sw_dbg_access; // [R11]
   wire dat_cap  = trig & ~brk_en & dstore; // [R10]
   wire cap      = (cof_cap | dat_cap) & ~full; // [R12]
   // Data store keeps the byte in the low half of the word
   wire [15:0] cap_word = dstore ? {8'h00, bus_data} : cpu_cof_addr;

   // Software writes to the control register
   wire ctrl_wr   = wr_en & (off == `BTU_OFF_CTRL);
   wire arm_start = ctrl_wr & acc_wd[`BTU_CTRL_ARM] & ~arm; // [R19]
   wire early_hlt = ctrl_wr & ~acc_wd[`BTU_CTRL_ARM] & arm & ~full; // [R15]

   // Pending word is pushed by the next capture or by an early halt
   wire push     = pend_v_ff & (cap | early_hlt) & ~full & ~arm_start; // [R15]
   wire fifo_rd  = rd_en & (off == `BTU_OFF_FIFOL);
   wire pop      = fifo_rd & (cnt_ff != {CW{1'b0}}) & ~arm_start; // [R18]
   wire fills    = push & ~pop & (cnt_ff == FULL_CNT - CNT_ONE);

   // Hardware ends capture on full, end trace or breakpoint
   wire end_trig = trig & ~brk_en & ~dstore & ~t_begin;
   wire hw_stop  = arm & (fills | end_trig | (trig & brk_en)); // [R12]

   // ****************************************
   // Next state
   // ****************************************

   reg [7:0]  nxt_ctrl;
   reg        nxt_storing;
   reg        nxt_trig_seen;
   reg        nxt_pend_v;
   reg [CW-1:0] nxt_cnt;
   reg [2:0]  nxt_ist;
   reg [2:0]  ist_set;
   reg [2:0]  ist_clr;

   // Control, storage window and counters
   always @* begin
      nxt_ctrl      = ctrl_ff;
      nxt_storing   = storing_ff;
      nxt_trig_seen = trig_seen_ff | trig;
      nxt_pend_v    = pend_v_ff;
      nxt_cnt       = cnt_ff;
      ist_set       = {hw_stop, fills, trig};
      ist_clr       = 3'h0;
      // Begin trace opens the storage window; end trace closes it
      if (trig & t_begin & ~dstore & ~brk_en) begin
         nxt_storing = 1'b1; // [R11]
      end
      if (end_trig) begin
         nxt_storing = 1'b0; // [R11]
      end
      // Pending word valid while a captured word waits for its slot
      if (cap) begin
         nxt_pend_v = 1'b1;
      end else if (push) begin
         nxt_pend_v = 1'b0;
      end
      // Hardware disarms itself on full, end trace or breakpoint
      if (hw_stop) begin
         nxt_ctrl[`BTU_CTRL_ARM] = 1'b0;
      end
      if (ctrl_wr) begin
         nxt_ctrl = acc_wd;
      end
      // Count follows each stored and each removed word
      nxt_cnt = cnt_ff + {{(CW-1){1'b0}}, push} - {{(CW-1){1'b0}}, pop}; // [R13] [R18]
      // Arming restarts the window and empties the FIFO
      if (arm_start) begin
         nxt_cnt       = {CW{1'b0}}; // [R19]
         nxt_pend_v    = 1'b0;
         nxt_trig_seen = 1'b0;
         nxt_storing   = ~acc_wd[`BTU_CTRL_BEGIN];
      end
      // Write one to clear the sticky event bits
      if (wr_en & (off == `BTU_OFF_ISTAT)) begin
         ist_clr = acc_wd[2:0];
      end
      // Set wins over a same-cycle clear
      nxt_ist = (ist_ff & ~ist_clr) | ist_set;
   end

   // ****************************************
   // State registers
   // ****************************************

   // Configuration and control flops
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         comp_a_ff     <= `BTU_RST_WORD;
         comp_b_ff     <= `BTU_RST_WORD;
         ctrl_ff       <= `BTU_RST_BYTE;
         mode_ff       <= `BTU_RST_MODE;
         imask_ff      <= `BTU_RST_IRQ;
         ist_ff        <= `BTU_RST_IRQ;
         trig_seen_ff  <= 1'b0;
         storing_ff    <= 1'b0;
         pend_v_ff     <= 1'b0;
         pend_ff       <= `BTU_RST_WORD;
         cnt_ff        <= {CW{1'b0}};
         wp_ff         <= {AW{1'b0}};
         rp_ff         <= {AW{1'b0}};
         cpu_break_req <= 1'b0;
      end else begin
         ctrl_ff       <= nxt_ctrl;
         ist_ff        <= nxt_ist;
         trig_seen_ff  <= nxt_trig_seen;
         storing_ff    <= nxt_storing;
         pend_v_ff     <= nxt_pend_v;
         cnt_ff        <= nxt_cnt;
         cpu_break_req <= trig & brk_en; // [R10]
         if (cap) begin
            pend_ff <= cap_word;
         end
         if (arm_start) begin
            wp_ff <= {AW{1'b0}};
            rp_ff <= {AW{1'b0}};
         end else begin
            if (push) begin
               wp_ff <= wp_ff + 1'b1;
            end
            if (pop) begin
               rp_ff <= rp_ff + 1'b1; // [R18]
            end
         end
         if (wr_en) begin
            case (off)
               `BTU_OFF_CAH:   comp_a_ff[15:8] <= acc_wd;
               `BTU_OFF_CAL:   comp_a_ff[7:0]  <= acc_wd;
               `BTU_OFF_CBH:   comp_b_ff[15:8] <= acc_wd;
               `BTU_OFF_CBL:   comp_b_ff[7:0]  <= acc_wd;
               `BTU_OFF_TRIG:  mode_ff         <= acc_wd[3:0];
               `BTU_OFF_IMASK: imask_ff        <= acc_wd[2:0];
               default: begin
               end
            endcase
         end
      end
   end

   // Capture storage, written in arrival order
   always @(posedge core_clk) begin
      if (push) begin
         mem[wp_ff] <= pend_ff; // [R1]
      end
   end

   // ****************************************
   // Read-back
   // ****************************************

   reg [7:0] rd_val;
   // Head of the FIFO; only shown while it holds a valid word
   wire [15:0] head = mem[rp_ff];
   // Read data multiplexer; oldest word at the head
   always @* begin
      case (off)
         `BTU_OFF_CAH:   rd_val = comp_a_ff[15:8];
         `BTU_OFF_CAL:   rd_val = comp_a_ff[7:0];
         `BTU_OFF_CBH:   rd_val = comp_b_ff[15:8];
         `BTU_OFF_CBL:   rd_val = comp_b_ff[7:0];
         `BTU_OFF_FIFOH: rd_val = (cnt_ff != {CW{1'b0}}) ? head[15:8] : 8'h00;
         `BTU_OFF_FIFOL: rd_val = (cnt_ff != {CW{1'b0}}) ? head[7:0] : 8'h00; // [R18]
         `BTU_OFF_CTRL:  rd_val = ctrl_ff;
         `BTU_OFF_TRIG:  rd_val = {4'h0, mode_ff};
         `BTU_OFF_STAT:  rd_val = {arm, trig_seen_ff, storing_ff, 1'b0, cnt_ff}; // [R13]
         `BTU_OFF_ISTAT: rd_val = {5'h00, ist_ff};
         `BTU_OFF_IMASK: rd_val = {5'h00, imask_ff};
         default:        rd_val = 8'h00;
      endcase
   end

   // Each port gets its data in the cycle after its read only
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         reg_rdata <= 8'h00;
         sw_rdata  <= 8'h00;
      end else begin
         reg_rdata <= (rd_en & ~sw_sel) ? rd_val : 8'h00;
         sw_rdata  <= (rd_en & sw_sel) ? rd_val : 8'h00; // [R16]
      end
   end

   // Level interrupt from unmasked sticky events
   assign irq = |(ist_ff & imask_ff);

endmodule

// ==== bus_trace_trigger_tb.sv ====
// Self-checking bench for the bus trace and trigger unit
module bus_trace_trigger_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        core_clk = 1'b0;
   logic        rst = 1'b1;
   logic [15:0] cpu_addr, cpu_exec_addr, cpu_cof_addr, reg_addr = 16'h0, sw_addr = 16'h0;
   logic [7:0]  cpu_rdata, cpu_wdata, reg_wdata = 8'h0, sw_wdata = 8'h0, reg_rdata, sw_rdata;
   logic        cpu_rw, cpu_valid, cpu_exec, cpu_cof, sw_dbg_access, cpu_break_req, irq;
   logic        reg_wr = 1'b0, reg_rd = 1'b0, sw_wr = 1'b0, sw_rd = 1'b0;
   int          n_errors = 0, checks_done = 0, brk_cnt = 0;
   logic [31:0] seed = 32'd19937;
   logic [15:0] q[$];
   logic [15:0] ca, cb, e, f, a, w;
   logic [7:0]  v, hi, ctl, d;
   logic [3:0]  md;
   logic [4:0]  k;

   btu_top btu_top_inst (.core_clk(core_clk), .rst(rst), .cpu_addr(cpu_addr),
      .cpu_rdata(cpu_rdata), .cpu_wdata(cpu_wdata), .cpu_rw(cpu_rw), .cpu_valid(cpu_valid),
      .cpu_exec(cpu_exec), .cpu_exec_addr(cpu_exec_addr), .cpu_cof(cpu_cof),
      .cpu_cof_addr(cpu_cof_addr), .sw_dbg_access(sw_dbg_access), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
      .sw_rdata(sw_rdata), .cpu_break_req(cpu_break_req), .irq(irq));
   btu_cpu_model btu_cpu_model_inst (.core_clk(core_clk), .cpu_addr(cpu_addr),
      .cpu_rdata(cpu_rdata), .cpu_wdata(cpu_wdata), .cpu_rw(cpu_rw), .cpu_valid(cpu_valid),
      .cpu_exec(cpu_exec), .cpu_exec_addr(cpu_exec_addr), .cpu_cof(cpu_cof),
      .cpu_cof_addr(cpu_cof_addr), .sw_dbg_access(sw_dbg_access));

   // Clock and break pulse counter
   always #4 core_clk = ~core_clk;
   always @(posedge core_clk) if (cpu_break_req === 1'b1) brk_cnt <= brk_cnt + 1;

   function automatic logic [15:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[15:0];
   endfunction

   // Expected trigger for one event; read data = d, write data = ~d
   function automatic bit hit(input logic [7:0] c, input logic [3:0] m, input logic [15:0] x,
                              input logic [7:0] y, input logic [4:0] j);
      bit am, bd;
      am = x == ca && (!c[3] || c[2] == j[4]);
      bd = ((c[3] && !c[2]) ? ~y : y) == cb[7:0];
      if (j[3] || !(c[5] ? j[1] : j[0])) return 0;
      case (m)
         0: return am;
         1: return am || x == cb;
         2: return am && bd;
         3: return am && !bd;
         4: return x >= ca && x <= cb;
         default: return x < ca || x > cb;
      endcase
   endfunction

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // One register cycle on the CPU port (sw=0) or link port (sw=1)
   task automatic acc(input bit sw, input bit wr, input logic [15:0] ad, input logic [7:0] wd,
                      output logic [7:0] r);
      @(posedge core_clk);
      {reg_addr, sw_addr, reg_wdata, sw_wdata} <= {ad, ad, wd, wd};
      {reg_wr, reg_rd, sw_wr, sw_rd} <= {wr & ~sw, ~wr & ~sw, wr & sw, ~wr & sw};
      @(posedge core_clk);
      {reg_wr, reg_rd, sw_wr, sw_rd} <= 4'h0;
      #1 r = sw ? sw_rdata : reg_rdata;
   endtask

   task automatic wr(input logic [15:0] ad, input logic [7:0] wd);
      acc(0, 1, ad, wd, v);
   endtask

   // Arm with breakpoint, run one event, count break pulses
   task automatic trial(input logic [7:0] c, input logic [3:0] m, input logic [15:0] x,
                        input logic [7:0] y, input logic [4:0] j);
      wr(16'h1806, 8'h00);
      wr(16'h1807, {4'h0, m});
      wr(16'h1806, 8'hc0 | c);
      brk_cnt = 0;
      btu_cpu_model_inst.cyc(x, y, ~y, j);
      repeat (3) @(posedge core_clk);
      chk("break count", hit(c, m, x, y, j), brk_cnt[15:0]);
   endtask

   // Configure, arm, then feed n captures
   task automatic fill(input logic [3:0] m, input logic [7:0] c, input int n);
      q = {};
      wr(16'h1806, 8'h00);
      wr(16'h1807, {4'h0, m});
      wr(16'h1806, c);
      if (c[4]) begin
         btu_cpu_model_inst.cyc(16'h0000, 8'h00, 8'h00, 5'b00100);
         btu_cpu_model_inst.cyc(ca, 8'h00, 8'h00, 5'b10001);
      end
      repeat (n) begin
         w = m == 6 ? {8'h00, cb[7:0]} : rnd();
         q.push_back(w);
         btu_cpu_model_inst.cyc(m == 6 ? ca : w, cb[7:0], cb[7:0], m == 6 ? 5'h11 : 5'h04);
      end
   endtask

   // Status, then n words oldest first over both ports
   task automatic drain(input int n);
      acc(0, 0, 16'h1808, 8'h00, v);
      chk("status", n[15:0], {v[7], v[3:0]});
      for (int i = 0; i < n; i++) begin
         acc(i[0], 0, 16'h1804, 8'h00, hi);
         acc(i[0], 0, 16'h1805, 8'h00, v);
         chk("fifo word", q[i], {hi, v});
         acc(0, 0, 16'h1808, 8'h00, v);
         chk("count", n[15:0] - 16'd1 - i[15:0], v[3:0]);
      end
   endtask

   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // ****
   // Main sequence
   // ****
   initial begin
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      ca = rnd() & 16'h7fff;
      cb = rnd() | 16'h8000;
      for (int i = 0; i < 4; i++) begin
         e = i[1] ? cb : ca;
         acc(i[0], 1, 16'h1800 + i[15:0], i[0] ? e[7:0] : e[15:8], v);
         acc(!i[0], 0, 16'h1800 + i[15:0], 8'h00, v);
         chk("comparator byte", i[0] ? e[7:0] : e[15:8], v);
      end
      acc(0, 0, 16'h180b, 8'h00, v);
      chk("hole read", 16'h0, v);
      acc(0, 0, 16'h0806, 8'h00, v);
      chk("low page read", 16'h0, v);
      @(posedge core_clk);
      {reg_rd, sw_rd, reg_addr, sw_addr} <= {2'b11, 16'h1800, 16'h1801};
      @(posedge core_clk);
      {reg_rd, sw_rd} <= 2'b00;
      #1 chk("shared read", {8'h00, ca[7:0]}, {reg_rdata, sw_rdata});
      $display("done: registers");
      for (int i = 0; i < 42; i++) begin
         md = i % 6;
         e = rnd();
         f = rnd();
         ctl = md < 4 ? e[7:0] & 8'h0c : 8'h00;
         a = e[9:8] == 0 ? ca : e[9:8] == 1 ? cb : e;
         d = f[1] ? cb[7:0] : f[0] ? ~cb[7:0] : f[15:8];
         k = {f[2], f[5:3] == 3'd0, 3'b001};
         trial(ctl, md, a, d, k);
      end
      trial(8'h20, 0, ca, 8'h00, 5'b10001);
      trial(8'h20, 0, ca, 8'h00, 5'b00010);
      $display("done: triggers");
      fill(0, 8'h80, 10);
      chk("irq masked", 16'h0, irq);
      wr(16'h180a, 8'h02);
      chk("irq full", 16'h1, irq);
      wr(16'h1809, 8'h02);
      chk("irq cleared", 16'h0, irq);
      drain(8);
      fill(0, 8'h80, 3);
      wr(16'h1806, 8'h00);
      drain(3);
      fill(0, 8'h90, 3);
      wr(16'h1806, 8'h00);
      drain(3);
      fill(6, 8'h80, 2);
      wr(16'h1806, 8'h00);
      drain(2);
      wr(16'h1809, 8'h07);
      fill(0, 8'h80, 3);
      btu_cpu_model_inst.cyc(ca, 8'h00, 8'h00, 5'b10001);
      wr(16'h1806, 8'h00);
      chk("irq end masked", 16'h0, irq);
      wr(16'h180a, 8'h04);
      chk("irq end", 16'h1, irq);
      drain(2);
      $display("done: capture");
      end_sim();
   end

   // Hang guard
   initial begin
      #50us;
      n_errors++;
      end_sim();
   end
endmodule
